// >>> hdl/clt_pkg.sv
// Shared constants for the CAN and LIN transceiver control logic
package clt_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 10_000_000;   // Reference clock rate
    localparam int unsigned LIN_TO_US       = 5_000;        // LIN dominant timeout, 5.0 ms
    localparam int unsigned LIN_TO_CYC      = (LIN_TO_US * (CLK_HZ / 1_000_000)); // Cycles
    localparam int unsigned CAN_TO_US       = 1_000;        // CAN dominant timeout, plain default
    localparam int unsigned CAN_TO_CYC      = (CAN_TO_US * (CLK_HZ / 1_000_000)); // Cycles
    localparam int unsigned TO_W            = 24;           // Timeout counter width

    // ------------------------------------------------------------
    // LIN baud rates in bit/s
    // ------------------------------------------------------------
    localparam int unsigned LIN_BAUD_SLOW   = 10_000;       // Slow rate
    localparam int unsigned LIN_BAUD_NORM   = 20_000;       // Normal rate
    localparam int unsigned LIN_BAUD_FAST   = 100_000;      // Flash / diagnostic rate

    // LIN rate selection code
    typedef enum logic [1:0] {
        CLT_BAUD_NORM = 2'h0,
        CLT_BAUD_SLOW = 2'h1,
        CLT_BAUD_FAST = 2'h3
    } clt_baud_t;

    // Driver guard states (Gray along idle, drive, tripped)
    typedef enum logic [1:0] {
        CLT_IDLE  = 2'h0,
        CLT_DRIVE = 2'h1,
        CLT_TRIP  = 2'h3
    } clt_guard_t;

    localparam logic [TO_W-1:0] CNT_ZERO = 24'h00_0000;     // Counter reset value
    localparam logic [TO_W-1:0] CNT_ONE  = 24'h00_0001;     // Counter step

    // Synchroniser reset: both transmits recessive, buses recessive, mode normal
    localparam logic [4:0]      SYNC_IDLE = 5'h03;

endpackage : clt_pkg

// >>> hdl/clt_guard.sv
// Dominant timeout guard for one transmit line
`timescale 1ns/1ps
module clt_guard #(
    parameter logic [clt_pkg::TO_W-1:0] LIMIT = 24'h00_0010   // Dominant cycles allowed
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // Control
    input  wire logic i_enable,     // Normal mode
    input  wire logic i_tx_dom,     // Synchronised transmit is dominant
    // Result
    output logic      o_drive,      // Driver may be on
    output logic      o_tripped     // Timeout has tripped
);

    // ------------------------------------------------------------
    // State and counter
    // ------------------------------------------------------------
    clt_pkg::clt_guard_t            state;      // Guard state
    clt_pkg::clt_guard_t            next_state; // Next guard state
    logic [clt_pkg::TO_W-1:0]       cnt;        // Dominant time counter
    logic [clt_pkg::TO_W-1:0]       next_cnt;   // Next counter value
    wire  logic                     at_limit = (cnt >= LIMIT); // Timeout reached

    // Next state: trip holds until transmit goes recessive or enable goes low
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            clt_pkg::CLT_IDLE: begin
                next_cnt = clt_pkg::CNT_ZERO;
                if (i_enable && i_tx_dom) begin
                    next_state = clt_pkg::CLT_DRIVE;
                    next_cnt   = clt_pkg::CNT_ONE;
                end
            end
            clt_pkg::CLT_DRIVE: begin
                if (!i_enable || !i_tx_dom) begin
                    next_state = clt_pkg::CLT_IDLE;
                    next_cnt   = clt_pkg::CNT_ZERO;
                end else if (at_limit) begin
                    next_state = clt_pkg::CLT_TRIP;
                end else begin
                    next_cnt   = cnt + clt_pkg::CNT_ONE;
                end
            end
            clt_pkg::CLT_TRIP: begin
                if (!i_tx_dom || !i_enable) begin
                    next_state = clt_pkg::CLT_IDLE;
                    next_cnt   = clt_pkg::CNT_ZERO;
                end
            end
            default: begin
                next_state = clt_pkg::CLT_IDLE;
                next_cnt   = clt_pkg::CNT_ZERO;
            end
        endcase
    end

    // State registers, frozen while i_ce low
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= clt_pkg::CLT_IDLE;
            cnt   <= clt_pkg::CNT_ZERO;
        end else if (i_ce) begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Drive permitted only in the drive state
    assign o_drive   = (state == clt_pkg::CLT_DRIVE);
    assign o_tripped = (state == clt_pkg::CLT_TRIP);

endmodule : clt_guard

// >>> hdl/clt_xcvr.sv
// Control logic for the CAN and LIN transceiver pins
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module clt_xcvr #(
    parameter logic [clt_pkg::TO_W-1:0] LIN_TO_CYCLES = clt_pkg::TO_W'(clt_pkg::LIN_TO_CYC),
    parameter logic [clt_pkg::TO_W-1:0] CAN_TO_CYCLES = clt_pkg::TO_W'(clt_pkg::CAN_TO_CYC)
) (
    // Clock, reset, enable
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    // Mode
    input  wire logic       i_low_power_off_mode,   // High: low power off
    input  wire logic [1:0] i_lin_baud_sel,         // LIN rate selection code
    // CAN side
    input  wire logic       i_can_tx,               // Controller transmit, low dominant
    input  wire logic       i_can_bus_dom,          // Bus comparator, high dominant
    output logic            o_can_drv_en,           // CANH and CANL drivers on
    output logic            o_can_bus_pd,           // Weak pulldowns on both lines
    output logic            o_can_rx_o,             // Receive output level
    output logic            o_can_rx_oe,            // Receive output enable
    output logic            o_can_timeout,          // CAN dominant timeout active
    // LIN side
    input  wire logic       i_lin_transmit_input,   // Controller transmit, low dominant
    input  wire logic       i_lin_bus_dom,          // LIN comparator, high dominant
    output logic            o_lin_drv_en,           // LIN low side transistor on
    output logic            o_lin_receive_output,   // LIN receive level
    output logic            o_lin_rx_oe,            // LIN receive output enable
    output logic            o_lin_timeout,          // LIN dominant timeout active
    output logic [16:0]     o_lin_baud              // Selected LIN rate in bit/s
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1;          // First stage
    logic [4:0] sync2;          // Second stage

    // Two flops on every pin input except i_lin_baud_sel; idle values are recessive
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1 <= clt_pkg::SYNC_IDLE;
            sync2 <= clt_pkg::SYNC_IDLE;
        end else if (i_ce) begin
            sync1 <= {i_low_power_off_mode, i_lin_bus_dom, i_can_bus_dom,
                      i_lin_transmit_input, i_can_tx};
            sync2 <= sync1;
        end
    end

    // Named synchronised signals
    wire logic can_tx_s   = sync2[0];   // Floating reads high through pull-up
    wire logic lin_tx_s   = sync2[1];
    wire logic can_bus_s  = sync2[2];
    wire logic lin_bus_s  = sync2[3];
    wire logic low_power_off_mode_s    = sync2[4];
    wire logic normal     = !low_power_off_mode_s;

    // ------------------------------------------------------------
    // Dominant timeout guards
    // ------------------------------------------------------------
    logic can_ok;               // CAN driver allowed
    logic can_trip;             // CAN trip state
    logic lin_ok;               // LIN driver allowed
    logic lin_trip;             // LIN trip state

    // CAN guard
    clt_guard #(.LIMIT(CAN_TO_CYCLES)) u_can_guard (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_enable  (normal),
        .i_tx_dom  (!can_tx_s),
        .o_drive   (can_ok),
        .o_tripped (can_trip)
    );

    // LIN guard, 5.0 ms limit
    clt_guard #(.LIMIT(LIN_TO_CYCLES)) u_lin_guard (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_enable  (normal),
        .i_tx_dom  (!lin_tx_s),
        .o_drive   (lin_ok),
        .o_tripped (lin_trip)
    );

    // ------------------------------------------------------------
    // Rate decode
    // ------------------------------------------------------------
    function automatic logic [16:0] baud_of(input logic [1:0] sel);
        case (sel)
            clt_pkg::CLT_BAUD_SLOW: baud_of = 17'(clt_pkg::LIN_BAUD_SLOW);
            clt_pkg::CLT_BAUD_FAST: baud_of = 17'(clt_pkg::LIN_BAUD_FAST);
            default:                baud_of = 17'(clt_pkg::LIN_BAUD_NORM);
        endcase
    endfunction : baud_of

    // Next output values
    wire logic        next_can_drv = normal && !can_tx_s && can_ok;
    wire logic        next_lin_drv = normal && !lin_tx_s && lin_ok;
    wire logic [16:0] next_baud    = baud_of(i_lin_baud_sel);

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // All outputs from flops; low power off releases receive pins
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_can_drv_en         <= 1'b0;
            o_can_bus_pd         <= 1'b0;
            o_can_rx_o           <= 1'b1;
            o_can_rx_oe          <= 1'b0;
            o_can_timeout        <= 1'b0;
            o_lin_drv_en         <= 1'b0;
            o_lin_receive_output <= 1'b1;
            o_lin_rx_oe          <= 1'b0;
            o_lin_timeout        <= 1'b0;
            o_lin_baud           <= 17'(clt_pkg::LIN_BAUD_NORM);
        end else if (i_ce) begin
            o_can_drv_en         <= next_can_drv;
            o_can_bus_pd         <= low_power_off_mode_s;
            o_can_rx_o           <= !can_bus_s;
            o_can_rx_oe          <= normal;
            o_can_timeout        <= can_trip;
            o_lin_drv_en         <= next_lin_drv;
            o_lin_receive_output <= !lin_bus_s;
            o_lin_rx_oe          <= normal;
            o_lin_timeout        <= lin_trip;
            o_lin_baud           <= next_baud;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_can_rec;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && can_tx_s |=> !o_can_drv_en;
    endproperty
    a_can_rec: assert property (p_can_rec) else $error("CAN driven while recessive");

    property p_can_trip;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && can_trip |=> !o_can_drv_en;
    endproperty
    a_can_trip: assert property (p_can_trip) else $error("CAN driven after trip");

    property p_can_rx;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_rstn && i_ce && normal |=> o_can_rx_oe && (o_can_rx_o == !$past(can_bus_s));
    endproperty
    a_can_rx: assert property (p_can_rx) else $error("CAN receive wrong");

    property p_can_off;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && low_power_off_mode_s |=> !o_can_rx_oe && !o_can_drv_en && o_can_bus_pd;
    endproperty
    a_can_off: assert property (p_can_off) else $error("CAN not off in low power");

    property p_lin_rec;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && (lin_tx_s || low_power_off_mode_s) |=> !o_lin_drv_en;
    endproperty
    a_lin_rec: assert property (p_lin_rec) else $error("LIN driven while recessive");

    property p_lin_trip;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && lin_trip |=> !o_lin_drv_en;
    endproperty
    a_lin_trip: assert property (p_lin_trip) else $error("LIN driven after trip");

    property p_lin_rx;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_rstn && i_ce |=> (o_lin_rx_oe == !$past(low_power_off_mode_s)) &&
                           (o_lin_receive_output == !$past(lin_bus_s));
    endproperty
    a_lin_rx: assert property (p_lin_rx) else $error("LIN receive wrong");

    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        lin_trip && !lin_tx_s && normal && i_ce |=> lin_trip;
    endproperty
    a_hold: assert property (p_hold) else $error("LIN trip released early");

    // CAN trip must also hold while transmit stays dominant
    property p_can_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        can_trip && !can_tx_s && normal && i_ce |=> can_trip;
    endproperty
    a_can_hold: assert property (p_can_hold) else $error("CAN trip released early");

    // Dominant transmit with guard armed turns drivers on
    property p_can_dom;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && normal && !can_tx_s && can_ok |=> o_can_drv_en;
    endproperty
    a_can_dom: assert property (p_can_dom) else $error("CAN not driven while dominant");

    // Pulldowns follow low power off exactly
    property p_can_pd;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_rstn && i_ce |=> (o_can_bus_pd == $past(low_power_off_mode_s));
    endproperty
    a_can_pd: assert property (p_can_pd) else $error("CAN pulldown wrong");

    // Low power off keeps LIN transistor off and receive released
    property p_lin_off;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && low_power_off_mode_s |=> !o_lin_drv_en && !o_lin_rx_oe;
    endproperty
    a_lin_off: assert property (p_lin_off) else $error("LIN not off in low power");

    // Fast rate code selects the diagnostic rate
    property p_baud_fast;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        i_ce && (i_lin_baud_sel == clt_pkg::CLT_BAUD_FAST) |=>
            (o_lin_baud == 17'(clt_pkg::LIN_BAUD_FAST));
    endproperty
    a_baud_fast: assert property (p_baud_fast) else $error("LIN fast rate wrong");

endmodule : clt_xcvr

// >>> verif/clt_bus_model.sv
// Bus model standing for the far nodes on the CAN and LIN wires
`timescale 1ns/1ps
module clt_bus_model (
    // Our bus drivers
    input  wire logic i_can_drv_en,
    input  wire logic i_lin_drv_en,
    // Other nodes pulling dominant
    input  wire logic i_can_ext_dom,
    input  wire logic i_lin_ext_dom,
    // Comparator levels, high dominant
    output logic      o_can_bus_dom,
    output logic      o_lin_bus_dom
);
    // CAN dominant when any node drives, biased recessive otherwise
    assign o_can_bus_dom = i_can_drv_en | i_can_ext_dom;
    // LIN pull-up holds recessive unless a transistor pulls low
    assign o_lin_bus_dom = i_lin_drv_en | i_lin_ext_dom;
endmodule : clt_bus_model

// >>> verif/tb_clt_xcvr.sv
// Self-checking bench for the transceiver control logic
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_clt_xcvr;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct {int sel; logic [16:0] exp;} clt_note_t;
    logic        i_ref_clk, i_rstn, i_ce, i_low_power_off_mode;
    logic [1:0]  i_lin_baud_sel;
    logic        i_can_tx, i_lin_transmit_input, can_ext, lin_ext;
    wire  logic  can_dom, lin_dom;
    logic        o_can_drv_en, o_can_bus_pd, o_can_rx_o, o_can_rx_oe, o_can_timeout;
    logic        o_lin_drv_en, o_lin_receive_output, o_lin_rx_oe, o_lin_timeout;
    logic [16:0] o_lin_baud;
    int          err_count, samples_checked;
    clt_note_t   notes[$];
    clt_note_t   cur;
    string       names[10] = '{"can_drv", "can_pd", "can_rx", "can_rx_oe", "can_to",
                               "lin_drv", "lin_rx", "lin_rx_oe", "lin_to", "lin_baud"};
    wire  logic [8:0] outs = {o_lin_timeout, o_lin_rx_oe, o_lin_receive_output,
                              o_lin_drv_en, o_can_timeout, o_can_rx_oe, o_can_rx_o,
                              o_can_bus_pd, o_can_drv_en};

    // Short counts keep the guard runs brief
    clt_xcvr #(.LIN_TO_CYCLES(24'h00_0014), .CAN_TO_CYCLES(24'h00_000a)) uut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce),
        .i_low_power_off_mode(i_low_power_off_mode), .i_lin_baud_sel(i_lin_baud_sel),
        .i_can_tx(i_can_tx), .i_can_bus_dom(can_dom), .o_can_drv_en(o_can_drv_en),
        .o_can_bus_pd(o_can_bus_pd), .o_can_rx_o(o_can_rx_o), .o_can_rx_oe(o_can_rx_oe),
        .o_can_timeout(o_can_timeout), .i_lin_transmit_input(i_lin_transmit_input),
        .i_lin_bus_dom(lin_dom), .o_lin_drv_en(o_lin_drv_en),
        .o_lin_receive_output(o_lin_receive_output), .o_lin_rx_oe(o_lin_rx_oe),
        .o_lin_timeout(o_lin_timeout), .o_lin_baud(o_lin_baud));

    clt_bus_model bus (
        .i_can_drv_en(o_can_drv_en), .i_lin_drv_en(o_lin_drv_en),
        .i_can_ext_dom(can_ext), .i_lin_ext_dom(lin_ext),
        .o_can_bus_dom(can_dom), .o_lin_bus_dom(lin_dom));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask : cyc

    // Queue one expected output
    task automatic note(input int sel, input logic [16:0] exp);
        notes.push_back('{sel, exp});
    endtask : note

    // Queue all nine level outputs, bit 0 first
    task automatic expect_vec(input logic [8:0] e);
        for (int i = 0; i < 9; i++) begin
            note(i, {16'h0000, e[i]});
        end
    endtask : expect_vec

    // Expected levels for normal mode, no trip
    function automatic logic [8:0] lvl(input logic c, ce, l, le);
        lvl = {1'b0, 1'b1, ~(l | le), l, 1'b0, 1'b1, ~(c | ce), 1'b0, c};
    endfunction : lvl

    // Hold one transmit line dominant through a trip and re-arm
    task automatic trip(input bit lin, input int lim);
        if (lin) i_lin_transmit_input <= 1'b0; else i_can_tx <= 1'b0;
        cyc(8);
        expect_vec(lin ? 9'h0ac : 9'h0c9);
        cyc(lim - 7);
        expect_vec(lin ? 9'h0ac : 9'h0c9);
        cyc(12);
        expect_vec(lin ? 9'h1cc : 9'h0dc);
        cyc(10);
        expect_vec(lin ? 9'h1cc : 9'h0dc);
        if (lin) i_lin_transmit_input <= 1'b1; else i_can_tx <= 1'b1;
        cyc(8);
        expect_vec(9'h0cc);
        if (lin) i_lin_transmit_input <= 1'b0; else i_can_tx <= 1'b0;
        cyc(8);
        expect_vec(lin ? 9'h0ac : 9'h0c9);
        if (lin) i_lin_transmit_input <= 1'b1; else i_can_tx <= 1'b1;
        cyc(8);
    endtask : trip

    task automatic print_verdict;
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Clock, watchdog and monitor
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        repeat (100000) @(posedge i_ref_clk);
        err_count++;
        print_verdict();
    end

    // Compare every queued note once outputs have settled
    always @(negedge i_ref_clk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            `CHK(names[cur.sel], cur.exp,
                 (cur.sel == 9) ? o_lin_baud : {16'h0000, outs[cur.sel]})
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        logic c, ce, l, le;
        i_rstn = 1'b0; i_ce = 1'b1; i_low_power_off_mode = 1'b0; i_lin_baud_sel = 2'h0;
        i_can_tx = 1'b1; i_lin_transmit_input = 1'b1; can_ext = 1'b0; lin_ext = 1'b0;
        err_count = 0; samples_checked = 0;
        void'($urandom(32'h8cbf));
        cyc(16);
        i_rstn <= 1'b1;
        cyc(8);
        expect_vec(9'h0cc);
        // Every rate code
        for (int i = 0; i < 4; i++) begin
            i_lin_baud_sel <= 2'(i);
            cyc(3);
            note(9, (i == 1) ? 17'h0_2710 : (i == 3) ? 17'h1_86a0 : 17'h0_4e20);
        end
        trip(1'b0, 10);
        trip(1'b1, 20);
        // Low power off with both transmit lines dominant
        i_can_tx <= 1'b0; i_lin_transmit_input <= 1'b0; i_low_power_off_mode <= 1'b1;
        cyc(8);
        note(0, 17'h0_0000);
        note(1, 17'h0_0001);
        note(3, 17'h0_0000);
        note(5, 17'h0_0000);
        note(7, 17'h0_0000);
        i_can_tx <= 1'b1; i_lin_transmit_input <= 1'b1; i_low_power_off_mode <= 1'b0;
        cyc(8);
        expect_vec(9'h0cc);
        // Clock enable low freezes every stage, then dominant passes
        i_ce <= 1'b0;
        i_can_tx <= 1'b0;
        cyc(8);
        expect_vec(9'h0cc);
        i_ce <= 1'b1;
        cyc(8);
        expect_vec(9'h0c9);
        i_can_tx <= 1'b1;
        cyc(8);
        expect_vec(9'h0cc);
        // Random levels from both controllers and far nodes
        repeat (30) begin
            {c, ce, l, le} = 4'($urandom());
            i_can_tx <= ~c; can_ext <= ce; i_lin_transmit_input <= ~l; lin_ext <= le;
            cyc(8);
            expect_vec(lvl(c, ce, l, le));
            i_can_tx <= 1'b1; can_ext <= 1'b0; i_lin_transmit_input <= 1'b1; lin_ext <= 1'b0;
            cyc(8);
        end
        cyc(2);
        print_verdict();
    end
endmodule : tb_clt_xcvr
